// ---- src/lrp_pkg.sv ----
// Package of the line receive output port: map, fields, timing.
// Assumes a 25 MHz system clock and a sampled line clock.
package lrp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_NS       = 40;
  // Master reference clock seen static this long counts as held
  localparam int MCLK_HOLD_NS     = 2000;
  localparam int MCLK_HOLD_CYC    = (MCLK_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  // No line pulse for this long raises the loss flag
  localparam int LOS_IDLE_NS      = 10240;
  localparam int LOS_IDLE_CYC     = (LOS_IDLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  // Window in which enough pulses clear the loss flag
  localparam int LOS_WIN_NS       = 5120;
  localparam int LOS_WIN_CYC      = LOS_WIN_NS / SYS_CLK_NS;
  localparam int LOS_CLR_PULSES   = 4;
  // Unipolar select must stay high beyond this many transmit clocks
  localparam int UBS_CYCLES       = 16;

  // ****************************************
  // Register map
  // ****************************************
  localparam int         ADDR_W      = 4;
  localparam int         DATA_W      = 32;
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_MASK    = 4'h8;
  localparam logic [3:0] OFS_STATE   = 4'hc;

  // Control fields
  localparam int CTRL_HOST_BIT   = 0;
  localparam int CTRL_AIS_BIT    = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status and mask fields
  localparam int EV_W            = 3;
  localparam int EV_LOS_SET      = 0;
  localparam int EV_LOS_CLR      = 1;
  localparam int EV_VIOL         = 2;
  localparam logic [2:0] EV_RST  = 3'h0;

  // State fields
  localparam int ST_LOS_BIT      = 0;
  localparam int ST_UNI_BIT      = 1;
  localparam int ST_MUX_BIT      = 2;
  localparam int ST_MODE_LSB     = 3;

  // Synchronised pin bundle positions
  localparam int PIN_W           = 8;
  localparam int PIN_LCLK        = 0;
  localparam int PIN_POS         = 1;
  localparam int PIN_NEG         = 2;
  localparam int PIN_MCLK        = 3;
  localparam int PIN_TRANSMIT_CLOCK_IN        = 4;
  localparam int PIN_UBS         = 5;
  localparam int PIN_MUX         = 6;
  localparam int PIN_CLOCK_EDGE_SELECT        = 7;

  // Output mode from the master reference clock pin
  typedef enum logic [2:0] {
    MODE_TRISTATE  = 3'b001,
    MODE_RECOV_CLK = 3'b010,
    MODE_RECOV_DAT = 3'b100
  } lrp_mode_type;

endpackage

// ---- src/lrp_sync2.sv ----
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
module lrp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // First stage feeds only the second
  always_comb begin
    nxt_meta = i_async;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign o_sync = sync_ff;
endmodule
`default_nettype wire

// ---- src/lrp_act_mon.sv ----
// Edge finder and inactivity timer for one synchronised level.
// Assumes the input is already on i_sys_clk.
`timescale 1ns/100ps
`default_nettype none
module lrp_act_mon #(
  parameter int LIMIT = 16
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_idle
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic          prev_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  assign o_rise = i_level & ~prev_ff;
  assign o_fall = ~i_level & prev_ff;

  // Count cycles since the last edge, saturating at the limit
  always_comb begin
    if (o_rise || o_fall) begin
      nxt_cnt = '0;
    end else if (cnt_ff != LIM) begin
      nxt_cnt = cnt_ff + CW'(1);
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prev_ff <= 1'b0;
      cnt_ff  <= '0;
    end else begin
      prev_ff <= i_level;
      cnt_ff  <= nxt_cnt;
    end
  end

  assign o_idle = (cnt_ff == LIM);
endmodule
`default_nettype wire

// ---- src/lrp_port.sv ----
// Receive output stage of one line port: clock, data, loss flag.
// Assumes sliced line pulses and all pins but reset and the register port asynchronous to i_sys_clk.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Recovered clock; master clock during loss
// - Master held high: clock is data XOR
// - Master held low: clock output floats
// - Master held low: data outputs float
// - Bipolar NRZ, high per pulse polarity
// - Edge select picks valid clock edge
// - Data recovery: RZ, polarity from edge select
// - Unipolar: data on positive, violation on negative
// - Hardware mode: outputs stay active in loss
// - Host mode: config bit picks alarm insertion
// - No transitions for interval raises loss
// - Enough transitions in window clear loss
// - Bus format select: low plain, high multiplexed
// - Unipolar after select high over 16 clocks
module lrp_port
  import lrp_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_line_clk,
  input  wire logic              i_line_receive_positive_leg,
  input  wire logic              i_line_receive_negative_leg,
  input  wire logic              i_master_clk,
  input  wire logic              i_transmit_clock_in,
  input  wire logic              i_unipolar_select_in,
  input  wire logic              i_host_bus_format_select,
  input  wire logic              i_clock_edge_select,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_rclk,
  output logic                   o_rclk_oe,
  output logic                   o_receive_positive_out,
  output logic                   o_receive_positive_oe,
  output logic                   o_receive_negative_out,
  output logic                   o_receive_negative_oe,
  output logic                   o_signal_loss_flag,
  output logic                   o_host_mux_mode,
  output logic                   o_irq
);
  localparam int WC = $clog2(LOS_WIN_CYC + 1);
  localparam int PC = $clog2(LOS_CLR_PULSES + 1);
  localparam int UC = $clog2(UBS_CYCLES + 2);

  // ****************************************
  // Pin synchronisation and edge finding
  // ****************************************
  logic [PIN_W-1:0] pin_s;
  logic             lclk_rise, lclk_fall, transmit_clock_in_rise, leg_rise;
  logic             mclk_idle, leg_idle, mclk_rise, mclk_fall;
  logic             pos_s, neg_s, mclk_s, clock_edge_select_s;

  lrp_sync2 #(.W(PIN_W)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_clock_edge_select, i_host_bus_format_select,
                 i_unipolar_select_in, i_transmit_clock_in, i_master_clk,
                 i_line_receive_negative_leg, i_line_receive_positive_leg,
                 i_line_clk}),
    .o_sync    (pin_s)
  );

  assign pos_s  = pin_s[PIN_POS];
  assign neg_s  = pin_s[PIN_NEG];
  assign mclk_s = pin_s[PIN_MCLK];
  assign clock_edge_select_s = pin_s[PIN_CLOCK_EDGE_SELECT];

  lrp_act_mon #(.LIMIT(LOS_WIN_CYC)) u_lclk (
    .i_sys_clk (i_sys_clk), .i_rst_n (i_rst_n), .i_level (pin_s[PIN_LCLK]),
    .o_rise (lclk_rise), .o_fall (lclk_fall), .o_idle ()
  );
  lrp_act_mon #(.LIMIT(UBS_CYCLES)) u_transmit_clock_in (
    .i_sys_clk (i_sys_clk), .i_rst_n (i_rst_n), .i_level (pin_s[PIN_TRANSMIT_CLOCK_IN]),
    .o_rise (transmit_clock_in_rise), .o_fall (), .o_idle ()
  );
  lrp_act_mon #(.LIMIT(MCLK_HOLD_CYC)) u_mclk (
    .i_sys_clk (i_sys_clk), .i_rst_n (i_rst_n), .i_level (mclk_s),
    .o_rise (mclk_rise), .o_fall (mclk_fall), .o_idle (mclk_idle)
  );
  lrp_act_mon #(.LIMIT(LOS_IDLE_CYC)) u_leg (
    .i_sys_clk (i_sys_clk), .i_rst_n (i_rst_n), .i_level (pos_s | neg_s),
    .o_rise (leg_rise), .o_fall (), .o_idle (leg_idle)
  );

  // ****************************************
  // Mode, loss of signal, unipolar select
  // ****************************************
  lrp_mode_type       mode_ff, nxt_mode;
  logic               los_ff, nxt_los;
  logic [WC-1:0]      win_ff, nxt_win;
  logic [PC-1:0]      pcnt_ff, nxt_pcnt;
  logic [UC-1:0]      ubs_ff, nxt_ubs;
  logic               unipolar;
  logic               los_clear_now;

  assign los_clear_now = los_ff && leg_rise && (pcnt_ff == PC'(LOS_CLR_PULSES - 1));
  assign unipolar      = (ubs_ff > UC'(UBS_CYCLES));

  // Master edges pick recovery, a static level picks by level.
  // Mode holds until then, so outputs stay floating after reset.
  always_comb begin
    nxt_mode = mode_ff;
    if (mclk_rise || mclk_fall) begin
      nxt_mode = MODE_RECOV_CLK;
    end else if (mclk_idle && mclk_s) begin
      nxt_mode = MODE_RECOV_DAT;
    end else if (mclk_idle) begin
      nxt_mode = MODE_TRISTATE;
    end
  end

  // Loss raised on silence, cleared by pulses counted in a window
  always_comb begin
    nxt_los  = los_ff;
    nxt_win  = '0;
    nxt_pcnt = '0;
    if (!los_ff) begin
      nxt_los = leg_idle;
    end else if (los_clear_now) begin
      nxt_los = 1'b0;
    end else if (win_ff != WC'(LOS_WIN_CYC - 1)) begin
      nxt_win  = win_ff + WC'(1);
      nxt_pcnt = pcnt_ff + PC'(leg_rise);
    end
  end

  // Select must stay high over consecutive transmit clocks
  always_comb begin
    if (!pin_s[PIN_UBS]) begin
      nxt_ubs = '0;
    end else if (transmit_clock_in_rise && !unipolar) begin
      nxt_ubs = ubs_ff + UC'(1);
    end else begin
      nxt_ubs = ubs_ff;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_ff <= MODE_TRISTATE;
      los_ff  <= 1'b0;
      win_ff  <= '0;
      pcnt_ff <= '0;
      ubs_ff  <= '0;
    end else begin
      mode_ff <= nxt_mode;
      los_ff  <= nxt_los;
      win_ff  <= nxt_win;
      pcnt_ff <= nxt_pcnt;
      ubs_ff  <= nxt_ubs;
    end
  end

  // ****************************************
  // Registers and interrupt
  // ****************************************
  logic [1:0]      ctrl_ff, nxt_ctrl;
  logic [EV_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask, ev;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic            irq_ff, nxt_irq, viol_now;
  logic            host_mode, ais_act;

  assign host_mode = ctrl_ff[CTRL_HOST_BIT];
  // Hardware mode never substitutes, host mode asks the config bit
  assign ais_act   = host_mode && ctrl_ff[CTRL_AIS_BIT] && los_ff;

  always_comb begin
    ev             = '0;
    ev[EV_LOS_SET] = !los_ff && nxt_los;
    ev[EV_LOS_CLR] = los_ff && !nxt_los;
    ev[EV_VIOL]    = viol_now;
    nxt_ctrl  = ctrl_ff;
    nxt_mask  = mask_ff;
    nxt_stat  = stat_ff;
    nxt_rdata = '0;
    if (i_wr && i_addr == OFS_CTRL) begin
      nxt_ctrl = i_wdata[1:0];
    end
    if (i_wr && i_addr == OFS_MASK) begin
      nxt_mask = i_wdata[EV_W-1:0];
    end
    if (i_wr && i_addr == OFS_STATUS) begin
      nxt_stat = stat_ff & ~i_wdata[EV_W-1:0];
    end
    nxt_stat = nxt_stat | ev;                     // Set wins over clear
    if (i_rd) begin
      case (i_addr)
        OFS_CTRL:   nxt_rdata[1:0]      = ctrl_ff;
        OFS_STATUS: nxt_rdata[EV_W-1:0] = stat_ff;
        OFS_MASK:   nxt_rdata[EV_W-1:0] = mask_ff;
        OFS_STATE: begin
          nxt_rdata[ST_LOS_BIT]              = los_ff;
          nxt_rdata[ST_UNI_BIT]              = unipolar;
          nxt_rdata[ST_MUX_BIT]              = pin_s[PIN_MUX];
          nxt_rdata[ST_MODE_LSB +: 3]        = mode_ff;
        end
        default:    nxt_rdata = '0;             // Unmapped reads zero
      endcase
    end
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_ff  <= CTRL_RST;
      mask_ff  <= EV_RST;
      stat_ff  <= EV_RST;
      rdata_ff <= '0;
      irq_ff   <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      mask_ff  <= nxt_mask;
      stat_ff  <= nxt_stat;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
    end
  end

  // ****************************************
  // Receive data path and output pins
  // ****************************************
  logic cap_pos_ff, cap_neg_ff, nxt_cap_pos, nxt_cap_neg;
  logic last_neg_ff, nxt_last_neg, ais_alt_ff, nxt_ais_alt;
  logic rclk_ff, nxt_rclk, oe_ff, nxt_oe, mux_ff;
  logic receive_positive_out_ff, nxt_receive_positive_out, receive_negative_out_ff, nxt_receive_negative_out, upd;

  // Capture mid-bit on the line clock rising edge
  assign nxt_cap_pos = lclk_rise ? pos_s : cap_pos_ff;
  assign nxt_cap_neg = lclk_rise ? neg_s : cap_neg_ff;
  // Update on the edge opposite to the one the framer samples
  assign upd = clock_edge_select_s ? lclk_fall : lclk_rise;
  // Two marks of one polarity in a row break the alternation
  assign viol_now = upd && unipolar && (cap_pos_ff ^ cap_neg_ff)
                    && (cap_neg_ff == last_neg_ff);

  always_comb begin
    nxt_last_neg = last_neg_ff;
    nxt_ais_alt  = ais_alt_ff;
    nxt_receive_positive_out     = receive_positive_out_ff;
    nxt_receive_negative_out     = receive_negative_out_ff;
    nxt_rclk     = pin_s[PIN_LCLK];
    nxt_oe       = (nxt_mode != MODE_TRISTATE);
    case (mode_ff)
      MODE_RECOV_DAT: begin
        // RZ pass-through, clock from the XOR for an outside recovery
        nxt_rclk = pos_s ^ neg_s;
        nxt_receive_positive_out = clock_edge_select_s ? pos_s : ~pos_s;
        nxt_receive_negative_out = clock_edge_select_s ? neg_s : ~neg_s;
      end
      MODE_RECOV_CLK: begin
        if (los_ff) begin
          nxt_rclk = mclk_s;
        end
        if (upd) begin
          if (ais_act) begin
            nxt_ais_alt = ~ais_alt_ff;
            nxt_receive_positive_out    = unipolar | ~ais_alt_ff;
            nxt_receive_negative_out    = ~unipolar & ais_alt_ff;
          end else if (unipolar) begin
            nxt_receive_positive_out = cap_pos_ff | cap_neg_ff;
            nxt_receive_negative_out = viol_now;
          end else begin
            nxt_receive_positive_out = cap_pos_ff;
            nxt_receive_negative_out = cap_neg_ff;
          end
          if (cap_pos_ff ^ cap_neg_ff) begin
            nxt_last_neg = cap_neg_ff;
          end
        end
      end
      default: begin
        nxt_rclk = 1'b0;
        nxt_receive_positive_out = 1'b0;
        nxt_receive_negative_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cap_pos_ff  <= 1'b0;
      cap_neg_ff  <= 1'b0;
      last_neg_ff <= 1'b0;
      ais_alt_ff  <= 1'b0;
      rclk_ff     <= 1'b0;
      oe_ff       <= 1'b0;
      receive_positive_out_ff     <= 1'b0;
      receive_negative_out_ff     <= 1'b0;
      mux_ff      <= 1'b0;
    end else begin
      cap_pos_ff  <= nxt_cap_pos;
      cap_neg_ff  <= nxt_cap_neg;
      last_neg_ff <= nxt_last_neg;
      ais_alt_ff  <= nxt_ais_alt;
      rclk_ff     <= nxt_rclk;
      oe_ff       <= nxt_oe;
      receive_positive_out_ff     <= nxt_receive_positive_out;
      receive_negative_out_ff     <= nxt_receive_negative_out;
      mux_ff      <= pin_s[PIN_MUX];
    end
  end

  assign o_rdata                = rdata_ff;
  assign o_rclk                 = rclk_ff;
  assign o_rclk_oe              = oe_ff;
  assign o_receive_positive_out = receive_positive_out_ff;
  assign o_receive_positive_oe  = oe_ff;
  assign o_receive_negative_out = receive_negative_out_ff;
  assign o_receive_negative_oe  = oe_ff;
  assign o_signal_loss_flag     = los_ff;
  assign o_host_mux_mode        = mux_ff;
  assign o_irq                  = irq_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  AST_LOS_SET: assert property (!los_ff && leg_idle |=> los_ff ##1 o_signal_loss_flag)
    else $error("loss flag not raised after silence");
  AST_LOS_CLR: assert property (los_clear_now |=> !o_signal_loss_flag)
    else $error("loss flag not cleared after pulses");
  AST_TRI_CLK: assert property (nxt_mode == MODE_TRISTATE |=> !o_rclk_oe)
    else $error("clock output driven with master low");
  AST_TRI_DAT: assert property (mode_ff == MODE_TRISTATE && nxt_mode == MODE_TRISTATE
                                |=> !o_receive_positive_oe && !o_receive_negative_oe)
    else $error("data outputs driven with master low");
  AST_XOR_CLK: assert property (mode_ff == MODE_RECOV_DAT |=> o_rclk == $past(pos_s ^ neg_s))
    else $error("clock is not the data XOR");
  AST_LOS_REF: assert property (mode_ff == MODE_RECOV_CLK && los_ff |=> o_rclk == $past(mclk_s))
    else $error("clock not switched to master on loss");
  AST_RZ_POL: assert property (mode_ff == MODE_RECOV_DAT && !clock_edge_select_s
                               |=> o_receive_positive_out == !$past(pos_s))
    else $error("RZ polarity wrong");
  AST_UNI_VIOL: assert property (mode_ff == MODE_RECOV_CLK && viol_now && !ais_act
                                 |=> o_receive_negative_out)
    else $error("violation not flagged");
  AST_AIS_ONES: assert property (mode_ff == MODE_RECOV_CLK && upd && ais_act && unipolar
                                 |=> o_receive_positive_out)
    else $error("alarm pattern not all ones");
  AST_HW_ACTIVE: assert property (mode_ff == MODE_RECOV_CLK && nxt_mode == MODE_RECOV_CLK
                                  && los_ff && !host_mode |=> o_receive_positive_oe)
    else $error("outputs idle in hardware loss");
  AST_UBS_SEL: assert property (pin_s[PIN_UBS] && transmit_clock_in_rise && ubs_ff == UC'(UBS_CYCLES)
                                |=> unipolar)
    else $error("unipolar not selected");
  AST_MUX: assert property (1'b1 |=> o_host_mux_mode == $past(pin_s[PIN_MUX]))
    else $error("bus format output stale");

  COV_LOS_CYCLE: cover property (ev[EV_LOS_SET] ##[1:1000] ev[EV_LOS_CLR]);
  COV_DATA_MODE: cover property (mode_ff == MODE_RECOV_DAT);
  COV_AIS:       cover property (ais_act && upd);
  COV_VIOL:      cover property (viol_now);
endmodule
`default_nettype wire

// ---- sim/lrp_line_src.sv ----
// Line-side source model: line clock and sliced pulse legs.
// Assumes the bench sets run and symbol; 320 ns clock while running.
`timescale 1ns/100ps
`default_nettype none
module lrp_line_src (
  input  wire logic       i_run,
  input  wire logic [1:0] i_sym,
  output logic            o_line_clk,
  output logic            o_pos,
  output logic            o_neg
);
  // ****************************************
  // Clock and return-to-zero pulses
  // ****************************************
  logic [1:0] leg;
  logic       alt;

  // Four 80 ns phases; pulses straddle the rise so capture is clean
  initial begin
    o_line_clk = 1'b0;
    leg        = 2'b00;
    alt        = 1'b0;
    #7;
    forever begin
      #80 o_line_clk = i_run;
      #80 leg = 2'b00;
      #80 o_line_clk = 1'b0;
      #80 alt = ~alt;
      leg = (i_sym == 2'b11) ? {alt, ~alt} : i_sym; // Symbol 3 sends alternate marks
    end
  end

  // Stopped line: clock stands low, legs show the symbol as levels
  assign o_pos = i_run ? leg[0] : i_sym[0];
  assign o_neg = i_run ? leg[1] : i_sym[1];
endmodule
`default_nettype wire

// ---- sim/lrp_port_tb_top.sv ----
// Testbench of the line receive output port: bus tasks and scenarios.
// Assumes lrp_line_src drives the line pins; the bench makes the master clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e));
module lrp_port_tb_top
  import lrp_pkg::*;
;
  // ****************************************
  // Signals, models and design
  // ****************************************
  logic              clk, rst_n, mclk, mclk_run, transmit_clock_in, unipolar_select_in, host_bus_format_select, clock_edge_select, run, wr, rd;
  logic [1:0]        sym;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic              lclk, pos, neg, rclk, rclk_oe, pos_out, pos_oe, neg_out, neg_oe;
  logic              signal_loss_flag, mux_out, irq, prev_rclk, prev_pos, edge_en;
  int                error_cnt, n_checks, rises, pos_seen, neg_seen, edge_bad, mcnt;
  logic [3:0]        regs [4] = '{OFS_CTRL, OFS_STATUS, OFS_MASK, 4'h2};

  lrp_line_src line (.i_run(run), .i_sym(sym), .o_line_clk(lclk), .o_pos(pos), .o_neg(neg));

  lrp_port dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_line_clk(lclk),
    .i_line_receive_positive_leg(pos), .i_line_receive_negative_leg(neg),
    .i_master_clk(mclk), .i_transmit_clock_in(transmit_clock_in), .i_unipolar_select_in(unipolar_select_in),
    .i_host_bus_format_select(host_bus_format_select), .i_clock_edge_select(clock_edge_select),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_rclk(rclk), .o_rclk_oe(rclk_oe),
    .o_receive_positive_out(pos_out), .o_receive_positive_oe(pos_oe),
    .o_receive_negative_out(neg_out), .o_receive_negative_oe(neg_oe),
    .o_signal_loss_flag(signal_loss_flag), .o_host_mux_mode(mux_out), .o_irq(irq)
  );

  // System clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Master clock: 16-cycle period, well inside the hold limit
  always @(posedge clk) begin
    if (mclk_run) begin
      mcnt <= (mcnt == 7) ? 0 : mcnt + 1;
      if (mcnt == 7) mclk <= ~mclk;
    end
  end

  // Output monitor: clock rises, marks seen, data changes off the valid edge
  always @(posedge clk) begin
    prev_rclk <= rclk;
    prev_pos  <= pos_out;
    if (rclk && !prev_rclk) rises <= rises + 1;
    if (pos_out) pos_seen <= pos_seen + 1;
    if (neg_out) neg_seen <= neg_seen + 1;
    if (edge_en && pos_out !== prev_pos && rclk !== !clock_edge_select) edge_bad <= edge_bad + 1;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Counters cleared off the sampling edge to avoid racing the monitor
  task automatic clr();
    @(negedge clk);
    rises = 0;
    pos_seen = 0;
    neg_seen = 0;
    edge_bad = 0;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic tx(input int n);
    repeat (n) begin
      @(posedge clk);
      transmit_clock_in <= 1'b1;
      @(posedge clk);
      transmit_clock_in <= 1'b0;
    end
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog: tests need about 2100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {rst_n, mclk, mclk_run, transmit_clock_in, unipolar_select_in, host_bus_format_select, run, wr, rd, edge_en} = '0;
    clock_edge_select = 1'b1;
    sym = 2'b00;
    addr = '0;
    wdata = '0;
    mcnt = 0;
    repeat (12) @(posedge clk);
    `CHK({rclk, rclk_oe, pos_oe, neg_oe, signal_loss_flag, irq}, 0)
    rst_n <= 1'b1;
    foreach (regs[i]) begin
      bus_rd(regs[i]);
      `CHK(d, 0)
    end
    // Master clock held low: everything floats
    cyc(80);
    bus_rd(OFS_STATE);
    `CHK(d[5:3], MODE_TRISTATE)
    `CHK({rclk_oe, pos_oe, neg_oe}, 0)
    done("float");
    // Clock recovery with single-polarity marks
    mclk_run <= 1'b1;
    run <= 1'b1;
    sym <= 2'b01;
    cyc(80);
    clr();
    cyc(80);
    bus_rd(OFS_STATE);
    `CHK(d[5:3], MODE_RECOV_CLK)
    `CHK({rclk_oe, pos_oe, neg_oe, signal_loss_flag}, 4'he)
    `CHK(rises inside {[9:11]}, 1)
    `CHK({pos_seen > 0, neg_seen == 0}, 2'b11)
    sym <= 2'b10;
    cyc(16);
    clr();
    cyc(80);
    `CHK({pos_seen == 0, neg_seen > 0}, 2'b11)
    // Both edge selections with alternate marks
    sym <= 2'b11;
    for (int v = 1; v >= 0; v--) begin
      clock_edge_select <= v[0];
      cyc(24);
      clr();
      edge_en = 1'b1;
      cyc(64);
      edge_en = 1'b0;
      `CHK({edge_bad, pos_seen > 0}, {32'h0, 1'b1})
    end
    done("clock recovery");
    // Loss of signal in hardware mode, then both host choices
    bus_wr(OFS_MASK, 32'h7);
    bus_wr(OFS_CTRL, 32'h0);
    sym <= 2'b00;
    cyc(300);
    `CHK({signal_loss_flag, irq, rclk_oe, pos_oe, neg_oe}, 5'h1f)
    bus_rd(OFS_STATUS);
    `CHK(d[2:0], 3'b001)
    clr();
    cyc(80);
    `CHK(rises inside {[4:6]}, 1)
    bus_wr(OFS_CTRL, 32'h1);
    clr();
    cyc(64);
    `CHK(pos_seen + neg_seen, 0)
    bus_wr(OFS_CTRL, 32'h3);
    clr();
    cyc(64);
    `CHK(pos_seen > 0 && neg_seen > 0, 1)
    bus_wr(OFS_MASK, 32'h0);
    cyc(2);
    `CHK(irq, 0)
    bus_wr(OFS_MASK, 32'h1);
    cyc(2);
    `CHK(irq, 1)
    bus_wr(OFS_CTRL, 32'h0);
    sym <= 2'b11;
    cyc(200);
    `CHK(signal_loss_flag, 0)
    bus_rd(OFS_STATUS);
    `CHK(d[2:0], 3'b011)
    bus_wr(OFS_STATUS, 32'h3);
    bus_rd(OFS_STATUS);
    `CHK({d[2:0], irq}, 0)
    done("loss");
    // Data recovery: static legs, both edge selects, symbols 0 to 2
    mclk_run <= 1'b0;
    mclk <= 1'b1;
    run <= 1'b0;
    cyc(70);
    bus_rd(OFS_STATE);
    `CHK(d[5:3], MODE_RECOV_DAT)
    for (int i = 0; i < 6; i++) begin
      clock_edge_select <= i[0];
      sym <= 2'(i >> 1);
      cyc(12);
      `CHK({neg_out, pos_out}, sym ^ {2{~clock_edge_select}})
      `CHK(rclk, ^sym)
    end
    done("data recovery");
    // Unipolar select over the transmit clock count, then violations
    mclk_run <= 1'b1;
    run <= 1'b1;
    sym <= 2'b11;
    clock_edge_select <= 1'b1;
    unipolar_select_in <= 1'b1;
    cyc(80);
    tx(16);
    bus_rd(OFS_STATE);
    `CHK(d[ST_UNI_BIT], 0)
    tx(1);
    cyc(4);
    bus_rd(OFS_STATE);
    `CHK(d[ST_UNI_BIT], 1)
    bus_wr(OFS_STATUS, 32'h7);
    clr();
    cyc(64);
    `CHK({pos_seen > 0, neg_seen == 0}, 2'b11)
    sym <= 2'b01;
    clr();
    cyc(64);
    `CHK(neg_seen > 0, 1)
    bus_rd(OFS_STATUS);
    `CHK(d[EV_VIOL], 1)
    // Unipolar loss with insertion: marks on positive only
    sym <= 2'b00;
    bus_wr(OFS_CTRL, 32'h3);
    cyc(300);
    clr();
    cyc(64);
    `CHK({signal_loss_flag, pos_seen > 0, neg_seen == 0}, 3'b111)
    unipolar_select_in <= 1'b0;
    cyc(6);
    bus_rd(OFS_STATE);
    `CHK(d[ST_UNI_BIT], 0)
    done("unipolar");
    // Bus format select follows the pin
    host_bus_format_select <= 1'b1;
    cyc(6);
    `CHK(mux_out, 1)
    bus_rd(OFS_STATE);
    `CHK(d[ST_MUX_BIT], 1)
    host_bus_format_select <= 1'b0;
    cyc(6);
    `CHK(mux_out, 0)
    done("bus format");
    summarize();
  end
endmodule
`default_nettype wire
